// ### logic/ctc_top.sv
// module: compact timer control with axi4-lite register slave
`timescale 1ns/100ps
// Overview of operation
// - pause stops counter, release resumes from value
// - setting pause leaves counter contents untouched
// - clock select picks one of seven sources, codes four and five both pick the sub clock
// - on/off clear stops counter, set runs it
// - on/off rising edge zeroes counter
// - on/off falling edge keeps residual count
// - on/off rise loads initial pin level in compare and pwm modes
// - period bits compare counter bits nine..seven
// - clear select zero: period match clears
// - period zero lets counter overflow
// - mode field: compare, pwm, timer
// - timer mode leaves output pin undriven
// - compare mode match a acts per function
// - pwm mode function: inactive, active, pwm
// - requested level equal initial shows no change
// - level bit: initial or pwm active level
// - counter readable, writes to it ignored
// - comparator a pair and period bits held
// - both control registers reset to zero
// - low bytes pass through shared byte buffer
// - clear select one: match a clears, except in pwm mode
// - clear select one: no period flag, except in pwm mode
// - polarity bit inverts pin in compare and pwm modes only
module ctc_top
  import ctc_pkg::*;
(
  input wire logic aclk, // system clock, 50 mhz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [ADDR_W-1:0] awaddr, // write byte address
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  output logic [1:0] bresp, // write response
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  input wire logic [ADDR_W-1:0] araddr, // read byte address
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  input wire logic external_clock_pin, // external count clock
  output logic timer_output_pin, // timer output level
  output logic timer_output_en_n, // low while the pin is driven
  output logic match_a_flag, // pulse on comparator a match
  output logic period_match_flag // pulse on period match
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // true when the prescaler's masked bits are all ones
  function automatic logic is_tc(input logic [5:0] v, input logic [5:0] m);
    return (v & m) == m;
  endfunction

  // true when an address falls on one of the six registers
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2] <= REG_CMPA_H[ADDR_W-1:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // state

  ctc_ctrl_a_t ca_q, ca_d;
  ctc_ctrl_b_t cb_q, cb_d;
  logic [9:0] cmpa_q, cmpa_d;
  logic [7:0] buf_q, buf_d;
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [7:0] wbyte_q, wbyte_d;
  logic wlane_q, wlane_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [7:0] rbyte_q, rbyte_d;
  logic wr_fire, rd_fire;

  logic [9:0] cnt_q, cnt_d, nxt;
  logic [5:0] pre_q, pre_d;
  logic [10:0] sub_q, sub_d;
  logic on_prev_q, out_q, out_d, pin_q, pin_d, oe_n_q, oe_n_d;
  logic amatch_q, amatch_d, pmatch_q, pmatch_d;
  logic on_rise, run, tick, src_tick, sub_tick, ext_rise, ext_fall;
  logic pwm, cmp, drive, use_a, a_hit, p_hit, clear, pwm_act, lvl;

  ////////////////////////////////////////////////////////////////////////////////
  // external clock pin

  ctc_pin_sync u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_i(external_clock_pin),
    .rise_o(ext_rise),
    .fall_o(ext_fall)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // register bus

  // address and data are parked separately, so either may come first
  assign awready = ~aw_held_q;
  assign wready = ~w_held_q;
  assign arready = ~rvalid_q;
  assign wr_fire = aw_held_q & w_held_q & ~bvalid_q;
  assign rd_fire = arvalid & ~rvalid_q;

  // next values of the bus and register file; a write beats a read on the buffer
  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wbyte_d = wbyte_q;
    wlane_d = wlane_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rbyte_d = rbyte_q;
    ca_d = ca_q;
    cb_d = cb_q;
    cmpa_d = cmpa_q;
    buf_d = buf_q;
    if (awvalid && !aw_held_q) begin
      aw_held_d = 1'b1;
      awaddr_d = awaddr;
    end
    if (wvalid && !w_held_q) begin
      w_held_d = 1'b1;
      wbyte_d = wdata[7:0];
      wlane_d = wstrb[0];
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    // reads: high byte hands its low partner to the buffer
    if (rd_fire) begin
      rvalid_d = 1'b1;
      rresp_d = reg_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
      case (araddr[ADDR_W-1:2])
        REG_CTRL_A[ADDR_W-1:2]: rbyte_d = ca_q;
        REG_CTRL_B[ADDR_W-1:2]: rbyte_d = cb_q;
        REG_CNT_L[ADDR_W-1:2]: rbyte_d = buf_q;
        REG_CNT_H[ADDR_W-1:2]: begin
          rbyte_d = {6'h00, cnt_q[9:8]};
          buf_d = cnt_q[7:0];
        end
        REG_CMPA_L[ADDR_W-1:2]: rbyte_d = buf_q;
        REG_CMPA_H[ADDR_W-1:2]: begin
          rbyte_d = {6'h00, cmpa_q[9:8]};
          buf_d = cmpa_q[7:0];
        end
        default: rbyte_d = 8'h00;
      endcase
    end
    // writes: counter pair is read-only and silently ignores writes
    if (wr_fire) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = reg_hit(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      if (wlane_q) begin
        case (awaddr_q[ADDR_W-1:2])
          REG_CTRL_A[ADDR_W-1:2]: ca_d = wbyte_q;
          REG_CTRL_B[ADDR_W-1:2]: cb_d = wbyte_q;
          REG_CMPA_L[ADDR_W-1:2]: buf_d = wbyte_q;
          REG_CMPA_H[ADDR_W-1:2]: cmpa_d = {wbyte_q[1:0], buf_q};
          default: buf_d = buf_d;
        endcase
      end
    end
  end

  // bus and register flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rbyte_q <= 8'h00;
      ca_q <= CTRL_A_RST;
      cb_q <= CTRL_B_RST;
      cmpa_q <= CNT_ZERO;
      buf_q <= 8'h00;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wbyte_q <= wbyte_d;
      wlane_q <= wlane_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rbyte_q <= rbyte_d;
      ca_q <= ca_d;
      cb_q <= cb_d;
      cmpa_q <= cmpa_d;
      buf_q <= buf_d;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = {24'h000000, rbyte_q};

  ////////////////////////////////////////////////////////////////////////////////
  // clock source selection

  // the high clock is taken equal to the system clock in this slice
  always_comb begin
    case (ca_q.clock_select_field)
      CKS_SYS_DIV4: src_tick = is_tc(pre_q, DIV4_MASK);
      CKS_SYS: src_tick = 1'b1;
      CKS_H_DIV16: src_tick = is_tc(pre_q, DIV16_MASK);
      CKS_H_DIV64: src_tick = is_tc(pre_q, DIV64_MASK);
      CKS_SUB_A, CKS_SUB_B: src_tick = sub_tick;
      CKS_EXT_RISE: src_tick = ext_rise;
      CKS_EXT_FALL: src_tick = ext_fall;
      default: src_tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // counter, comparators and output pin

  assign sub_tick = sub_q == SUB_LAST;
  assign on_rise = ca_q.on_off_bit & ~on_prev_q;
  assign run = ca_q.on_off_bit & ~ca_q.pause_bit;
  assign tick = run & src_tick;
  assign nxt = cnt_q + 10'h001;
  assign pwm = cb_q.mode_field == MODE_PWM;
  assign cmp = cb_q.mode_field == MODE_CMP;
  assign drive = pwm | cmp;
  assign use_a = cb_q.counter_clear_select_bit & ~pwm;
  // a zero comparator a never matches, so the counter overflows instead
  assign a_hit = tick & (cmpa_q != CNT_ZERO) & (nxt == cmpa_q);
  assign p_hit = tick & ((ca_q.period_compare_bits == 3'h0) ? (cnt_q == CNT_MAX) :
                 ((nxt[9:7] == ca_q.period_compare_bits) && (nxt[6:0] == 7'h00)));
  assign clear = use_a ? a_hit : p_hit;

  // pwm active phase: never, always, or while the count is below comparator a
  always_comb begin
    case (cb_q.output_function_field)
      FN_PWM_INACT: pwm_act = 1'b0;
      FN_PWM_ACT: pwm_act = 1'b1;
      FN_PWM_RUN: pwm_act = cnt_q < cmpa_q;
      default: pwm_act = 1'b0;
    endcase
  end

  // next values for the timing group
  always_comb begin
    pre_d = pre_q + 6'h01;
    sub_d = sub_tick ? 11'h000 : sub_q + 11'h001;
    cnt_d = cnt_q;
    out_d = out_q;
    amatch_d = a_hit & ~on_rise;
    pmatch_d = p_hit & ~use_a & ~on_rise;
    if (on_rise) begin
      cnt_d = CNT_ZERO;
    end else if (tick) begin
      cnt_d = clear ? CNT_ZERO : nxt;
    end
    if (on_rise && drive) begin
      out_d = cb_q.initial_level_bit;
    end else if (cmp && a_hit) begin
      // asking for the level already shown leaves the pin as it is
      case (cb_q.output_function_field)
        FN_NONE: out_d = out_q;
        FN_LOW: out_d = 1'b0;
        FN_HIGH: out_d = 1'b1;
        FN_TOGGLE: out_d = ~out_q;
        default: out_d = out_q;
      endcase
    end
    lvl = pwm ? (pwm_act ? cb_q.initial_level_bit : ~cb_q.initial_level_bit) : out_d;
    pin_d = drive ? (lvl ^ cb_q.output_polarity_bit) : 1'b0;
    oe_n_d = ~drive;
  end

  // timing flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= 6'h00;
      sub_q <= 11'h000;
      cnt_q <= CNT_ZERO;
      on_prev_q <= 1'b0;
      out_q <= 1'b0;
      pin_q <= 1'b0;
      oe_n_q <= 1'b0;
      amatch_q <= 1'b0;
      pmatch_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      sub_q <= sub_d;
      cnt_q <= cnt_d;
      on_prev_q <= ca_q.on_off_bit;
      out_q <= out_d;
      pin_q <= pin_d;
      oe_n_q <= oe_n_d;
      amatch_q <= amatch_d;
      pmatch_q <= pmatch_d;
    end
  end

  assign timer_output_pin = pin_q;
  assign timer_output_en_n = oe_n_q;
  assign match_a_flag = amatch_q;
  assign period_match_flag = pmatch_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking ck @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_pause_holds: assert property (
    (ca_q.on_off_bit && ca_q.pause_bit && on_prev_q) |=> $stable(cnt_q))
    else $error("counter moved while paused");

  a_off_holds: assert property (
    (!ca_q.on_off_bit) |=> $stable(cnt_q))
    else $error("counter moved while off");

  a_on_clears: assert property (
    on_rise |=> (cnt_q == CNT_ZERO) && !match_a_flag && !period_match_flag)
    else $error("on rise did not zero counter");

  a_init_level: assert property (
    (on_rise && cb_q.mode_field == MODE_CMP) |=> (out_q == $past(cb_q.initial_level_bit)))
    else $error("initial level not loaded");

  a_idle_stable: assert property (
    (!tick && !on_rise) |=> $stable(cnt_q))
    else $error("counter moved without tick");

  a_step_one: assert property (
    (tick && !on_rise && !clear) |=> (cnt_q == $past(nxt)))
    else $error("counter did not step by one");

  a_period_clear: assert property (
    (period_match_flag && !$past(cb_q.counter_clear_select_bit)) |-> (cnt_q == CNT_ZERO))
    else $error("period match left counter set");

  a_no_pflag: assert property (
    ($past(cb_q.counter_clear_select_bit) && $past(cb_q.mode_field) != MODE_PWM)
    |-> !period_match_flag)
    else $error("period flag with clear select one");

  a_timer_undriven: assert property (
    (cb_q.mode_field == MODE_TIMER) [*2] |-> timer_output_en_n && !timer_output_pin)
    else $error("pin driven in timer mode");

  a_toggle_flip: assert property (
    (cmp && a_hit && !on_rise && cb_q.output_function_field == FN_TOGGLE)
    |=> (out_q != $past(out_q)))
    else $error("toggle did not flip pin");

  c_on_rise: cover property (on_rise ##[1:20] tick);
  c_match_a: cover property (match_a_flag && cmp);
  c_period: cover property (period_match_flag && (cnt_q == CNT_ZERO));
  c_pwm_run: cover property (pwm && cb_q.output_function_field == FN_PWM_RUN && tick);

endmodule

// ### logic/ctc_pkg.sv
// package: constants, register map and field layouts of the compact timer control
package ctc_pkg;

  // clock rates and divider counts
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned SUB_CLK_HZ = 32_768;
  localparam int unsigned SUB_DIV = CLK_HZ / SUB_CLK_HZ;
  localparam logic [10:0] SUB_LAST = 11'(SUB_DIV - 1);
  localparam int unsigned DIV4 = 4;
  localparam int unsigned DIV16 = 16;
  localparam int unsigned DIV64 = 64;
  localparam logic [5:0] DIV4_MASK = 6'(DIV4 - 1);
  localparam logic [5:0] DIV16_MASK = 6'(DIV16 - 1);
  localparam logic [5:0] DIV64_MASK = 6'(DIV64 - 1);

  // counter geometry
  localparam int unsigned CNT_W = 10;
  localparam logic [9:0] CNT_MAX = 10'h3ff;
  localparam logic [9:0] CNT_ZERO = 10'h000;

  // register byte addresses
  localparam int unsigned ADDR_W = 5;
  localparam logic [4:0] REG_CTRL_A = 5'h00;
  localparam logic [4:0] REG_CTRL_B = 5'h04;
  localparam logic [4:0] REG_CNT_L = 5'h08;
  localparam logic [4:0] REG_CNT_H = 5'h0c;
  localparam logic [4:0] REG_CMPA_L = 5'h10;
  localparam logic [4:0] REG_CMPA_H = 5'h14;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // clock select codes
  localparam logic [2:0] CKS_SYS_DIV4 = 3'h0;
  localparam logic [2:0] CKS_SYS = 3'h1;
  localparam logic [2:0] CKS_H_DIV16 = 3'h2;
  localparam logic [2:0] CKS_H_DIV64 = 3'h3;
  localparam logic [2:0] CKS_SUB_A = 3'h4;
  localparam logic [2:0] CKS_SUB_B = 3'h5;
  localparam logic [2:0] CKS_EXT_RISE = 3'h6;
  localparam logic [2:0] CKS_EXT_FALL = 3'h7;

  // operating modes
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_UNDEF = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TIMER = 2'h3;

  // output function codes
  localparam logic [1:0] FN_NONE = 2'h0;
  localparam logic [1:0] FN_LOW = 2'h1;
  localparam logic [1:0] FN_HIGH = 2'h2;
  localparam logic [1:0] FN_TOGGLE = 2'h3;
  localparam logic [1:0] FN_PWM_INACT = 2'h0;
  localparam logic [1:0] FN_PWM_ACT = 2'h1;
  localparam logic [1:0] FN_PWM_RUN = 2'h2;

  // field layouts, msb first as in the byte
  typedef struct packed {
    logic pause_bit;
    logic [2:0] clock_select_field;
    logic on_off_bit;
    logic [2:0] period_compare_bits;
  } ctc_ctrl_a_t;

  typedef struct packed {
    logic [1:0] mode_field;
    logic [1:0] output_function_field;
    logic initial_level_bit;
    logic output_polarity_bit;
    logic period_duty_swap_bit;
    logic counter_clear_select_bit;
  } ctc_ctrl_b_t;

  localparam ctc_ctrl_a_t CTRL_A_RST = 8'h00;
  localparam ctc_ctrl_b_t CTRL_B_RST = 8'h00;

endpackage

// ### logic/ctc_pin_sync.sv
// module: three-stage synchroniser and edge detector for the external clock pin
`timescale 1ns/100ps
module ctc_pin_sync (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic pin_i, // raw external pin
  output logic rise_o, // one-cycle pulse per accepted rising edge
  output logic fall_o // one-cycle pulse per accepted falling edge
);

  logic s1_q, s2_q, s3_q, lvl_q, rise_q, fall_q;
  logic lvl_d, rise_d, fall_d;

  // a new level is accepted only once stages two and three agree
  always_comb begin
    lvl_d = lvl_q;
    rise_d = 1'b0;
    fall_d = 1'b0;
    if (s2_q == s3_q && s3_q != lvl_q) begin
      lvl_d = s3_q;
      rise_d = s3_q;
      fall_d = ~s3_q;
    end
  end

  // s1 feeds only s2, so metastability never reaches the compare
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign rise_o = rise_q;
  assign fall_o = fall_q;

endmodule

// ### dv/test_ctc_top.sv
// testbench: register, counter and output pin scenarios for the compact timer control
`timescale 1ns/100ps
module test_ctc_top;
  import ctc_pkg::*;
  ////////////////////////////////////////
  // bench signals
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, ext_pin, pin, en_n, flag_a, flag_p;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [7:0] r8;
  logic [9:0] c0, c1, dlt;
  int err_total, n_checks, cyc, n;

  // device under test
  ctc_top dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .external_clock_pin(ext_pin),
    .timer_output_pin(pin), .timer_output_en_n(en_n), .match_a_flag(flag_a),
    .period_match_flag(flag_p)
  );

  // free-running 50 mhz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // watchdog: a hang counts as a mismatch, the whole run needs well under this
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      test_done();
    end
  end

  ////////////////////////////////////////
  // compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // axi4-lite write: address and data offered together, each released when taken
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bit aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wstrb <= 4'h1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk(32'(bresp), 32'(RESP_OKAY));
    bready <= 1'b0;
  endtask

  // axi4-lite read with expected response code
  task automatic rd(input logic [4:0] a, input logic [1:0] er, output logic [7:0] d);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata[7:0];
    chk(32'(rresp), 32'(er));
    rready <= 1'b0;
  endtask

  // counter snapshot: the high read latches the low byte, so order matters
  task automatic rd_cnt(output logic [9:0] v);
    logic [7:0] h, l;
    rd(REG_CNT_H, RESP_OKAY, h);
    rd(REG_CNT_L, RESP_OKAY, l);
    v = {h[1:0], l};
  endtask

  // cycles between two successive pulses of one flag
  task automatic flag_gap(input bit sel_a, output int g);
    do @(posedge aclk); while ((sel_a ? flag_a : flag_p) !== 1'b1);
    g = 0;
    do begin
      @(posedge aclk);
      g++;
    end while ((sel_a ? flag_a : flag_p) !== 1'b1);
  endtask

  ////////////////////////////////////////
  // reset values, unmapped place, read-only counter, byte buffer
  task automatic t_regs();
    rd(REG_CTRL_A, RESP_OKAY, r8);
    chk(32'(r8), 32'h0);
    rd(REG_CTRL_B, RESP_OKAY, r8);
    chk(32'(r8), 32'h0);
    rd(5'h18, RESP_SLVERR, r8);
    chk(32'(r8), 32'h0);
    wr(REG_CNT_H, 8'h03);
    wr(REG_CNT_L, 8'hff);
    rd_cnt(c0);
    chk(32'(c0), 32'h0);
    wr(REG_CMPA_L, 8'h5a);
    wr(REG_CMPA_H, 8'h03);
    // a stray low write only fills the buffer; the high read overwrites it
    wr(REG_CMPA_L, 8'h11);
    rd(REG_CMPA_H, RESP_OKAY, r8);
    chk(32'(r8), 32'h3);
    rd(REG_CMPA_L, RESP_OKAY, r8);
    chk(32'(r8), 32'h5a);
  endtask

  // pause holds, off keeps the residue, on clears
  task automatic t_run();
    wr(REG_CTRL_A, 8'h18);
    repeat (200) @(posedge aclk);
    wr(REG_CTRL_A, 8'h98);
    rd_cnt(c0);
    repeat (100) @(posedge aclk);
    rd_cnt(c1);
    chk(32'(c1), 32'(c0));
    chk(32'(c0 > 10'd150), 32'h1);
    wr(REG_CTRL_A, 8'h18);
    rd_cnt(c1);
    dlt = c1 - c0;
    chk(32'(dlt > 10'd0 && dlt < 10'd40), 32'h1);
    wr(REG_CTRL_A, 8'h10);
    rd_cnt(c0);
    repeat (100) @(posedge aclk);
    rd_cnt(c1);
    chk(32'(c1), 32'(c0));
    wr(REG_CTRL_A, 8'h18);
    rd_cnt(c1);
    chk(32'(c1 < 10'd30), 32'h1);
    wr(REG_CTRL_A, 8'h00);
  endtask

  // internal sources: ticks over a window, slack covers the bus read time
  task automatic t_rate();
    int dv[6] = '{4, 1, 16, 64, SUB_DIV, SUB_DIV};
    int gp;
    for (int k = 0; k < 6; k++) begin
      gp = (k < 4) ? 512 : 3050;
      wr(REG_CTRL_A, {1'b0, 3'(k), 4'h8});
      rd_cnt(c0);
      repeat (gp) @(posedge aclk);
      rd_cnt(c1);
      dlt = c1 - c0;
      chk(32'(int'(dlt) >= gp / dv[k] - 1 && int'(dlt) <= (gp + 20) / dv[k] + 1), 32'h1);
      wr(REG_CTRL_A, 8'h00);
    end
  endtask

  // external pin: five rises and four falls, each level held four cycles
  task automatic t_ext();
    for (int k = 6; k < 8; k++) begin
      wr(REG_CTRL_A, {1'b0, 3'(k), 4'h8});
      rd_cnt(c0);
      for (int e = 0; e < 5; e++) begin
        ext_pin <= 1'b1;
        repeat (4) @(posedge aclk);
        if (e < 4) ext_pin <= 1'b0;
        repeat (4) @(posedge aclk);
      end
      repeat (10) @(posedge aclk);
      rd_cnt(c1);
      dlt = c1 - c0;
      chk(32'(dlt), (k == 6) ? 32'h5 : 32'h4);
      ext_pin <= 1'b0;
      wr(REG_CTRL_A, 8'h00);
    end
  endtask

  // period lengths, then clear on match a with the period flag suppressed
  task automatic t_period();
    logic [2:0] rp[3] = '{3'h1, 3'h0, 3'h7};
    int ex[3] = '{128, 1024, 896};
    for (int k = 0; k < 3; k++) begin
      wr(REG_CTRL_A, {5'h03, rp[k]});
      flag_gap(1'b0, n);
      chk(32'(n), 32'(ex[k]));
      wr(REG_CTRL_A, 8'h00);
    end
    // match a beyond 128 so a period match would be seen if not suppressed
    wr(REG_CMPA_L, 8'hc8);
    wr(REG_CMPA_H, 8'h00);
    wr(REG_CTRL_B, 8'h01);
    wr(REG_CTRL_A, 8'h19);
    flag_gap(1'b1, n);
    chk(32'(n), 32'd200);
    n = 0;
    repeat (450) begin
      @(posedge aclk);
      if (flag_p === 1'b1) n++;
    end
    chk(32'(n), 32'h0);
    wr(REG_CTRL_A, 8'h10);
  endtask

  // compare mode: every action code, both initial levels, both polarities
  task automatic t_cmp();
    logic ex;
    wr(REG_CMPA_L, 8'h28);
    wr(REG_CMPA_H, 8'h00);
    for (int k = 0; k < 16; k++) begin
      wr(REG_CTRL_A, 8'h10);
      wr(REG_CTRL_B, {4'(k & 3), k[2], k[3], 2'b01});
      wr(REG_CTRL_A, 8'h18);
      repeat (2) @(posedge aclk);
      chk(32'(pin), 32'(k[2] ^ k[3]));
      chk(32'(en_n), 32'h0);
      do @(posedge aclk); while (flag_a !== 1'b1);
      repeat (3) @(posedge aclk);
      case (k & 3)
        0: ex = k[2];
        1: ex = 1'b0;
        2: ex = 1'b1;
        default: ex = !k[2];
      endcase
      chk(32'(pin), 32'(ex ^ k[3]));
    end
  endtask

  // pwm forced levels and duty, then timer mode releases the pin
  task automatic t_pwm();
    for (int k = 0; k < 4; k++) begin
      wr(REG_CTRL_A, 8'h10);
      wr(REG_CTRL_B, {2'b10, 2'(k & 1), k[1], 3'b000});
      wr(REG_CTRL_A, 8'h19);
      repeat (4) @(posedge aclk);
      chk(32'(pin), 32'((k & 1) ? k[1] : !k[1]));
    end
    wr(REG_CTRL_A, 8'h10);
    wr(REG_CTRL_B, 8'ha8);
    wr(REG_CTRL_A, 8'h19);
    repeat (20) @(posedge aclk);
    n = 0;
    repeat (128) begin
      @(posedge aclk);
      if (pin === 1'b1) n++;
    end
    chk(32'(n), 32'd40);
    chk(32'(en_n), 32'h0);
    wr(REG_CTRL_A, 8'h10);
    wr(REG_CTRL_B, 8'hc0);
    repeat (2) @(posedge aclk);
    chk(32'(en_n), 32'h1);
    // the undefined mode code is handled like timer mode and releases the pin
    wr(REG_CTRL_B, 8'h40);
    repeat (2) @(posedge aclk);
    chk(32'(en_n), 32'h1);
    chk(32'(pin), 32'h0);
  endtask

  ////////////////////////////////////////
  // reset, scenarios, verdict
  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    awaddr = 5'h00;
    wvalid = 1'b0;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    bready = 1'b0;
    arvalid = 1'b0;
    araddr = 5'h00;
    rready = 1'b0;
    ext_pin = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_run();
    t_rate();
    t_ext();
    t_period();
    t_cmp();
    t_pwm();
    test_done();
  end
endmodule
